// >>> logic/pllc_top.sv
// PLL lock and bandwidth control: dividers, lock detector, filter mode.
// Assumes MCLK is the crystal clock; VCO_CLK is the VCO sense line.
//
// Overview of operation
// - Slow clock tick divides crystal by 4 to 252 in steps of 4.
// - Reference tick divides crystal by a programmable 1 to 8.
// - Feedback divider makes VCO an integer multiple 1 to 64 of reference.
// - Selected PLL keeps running in WAIT; software may turn it off.
// - STOP suspends PLL; after stabilisation it resumes if auto is set.
// - Lock detector compares divided feedback against final reference frequency.
// - Filter-mode bit zero means acquisition, one means tracking.
// - Auto mode: lock detector switches acquisition and tracking itself.
// - Auto mode: track bit read-only, set inside track, cleared outside untrack.
// - Lock bit read-only, set inside lock, cleared outside unlock tolerance.
// - Lock change in either direction requests interrupt when enabled.
// - Manual mode disables auto switching and STOP resume; lock features stay active.
// - Manual mode: track bit writable and directly selects filter mode.
// - Module, CAN and debug clock sources each follow a select bit.
// - Reset sets power-on and monitor enable, clears limp-home disable.
`timescale 1ns/1ps
`default_nettype none
module pllc_top (
    input wire logic MCLK, // Crystal clock, 100 MHz
    input wire logic SYS_RST, // Async reset, high
    input wire logic [2:0] ADDR, // Register address
    input wire logic [7:0] WR_DATA, // Write data
    input wire logic WR_EN, // Write strobe
    input wire logic RD_EN, // Read strobe
    input wire logic VCO_CLK, // VCO sense, asynchronous
    input wire logic PLL_SUPPLY_OK, // PLL supply present, asynchronous
    input wire logic STOP_MODE, // Device in STOP
    output logic [7:0] RD_DATA, // Read data, cycle after strobe
    output logic IRQ, // Lock change interrupt, level
    output logic PLL_ENABLE, // Powers the analog loop
    output logic FILTER_TRACK, // Loop filter in tracking
    output logic PLL_LOCKED, // Lock status
    output logic CLK_MON_EN, // Clock monitor enable
    output logic LIMP_HOME_DIS, // Limp-home disable
    output logic [2:0] CLK_SEL, // Debug, CAN, module selects
    output logic REF_TICK, // Final reference tick
    output logic SLOW_TICK // Slow clock tick
);
    pllc_pkg::pllc_ctrl_t ctrl;
    pllc_pkg::pllc_ctrl_t next_ctrl;
    pllc_pkg::pllc_clksel_t clksel;
    pllc_pkg::pllc_clksel_t next_clksel;
    logic [2:0] refdiv;
    logic [2:0] next_refdiv;
    logic [5:0] mult;
    logic [5:0] next_mult;
    logic [5:0] slow;
    logic [5:0] next_slow;
    logic irq_stat;
    logic next_irq_stat;
    logic lock_change_irq_enable;
    logic next_lock_change_irq_enable;
    logic [7:0] next_rd_data;
    logic next_irq;

    pllc_pkg::pllc_state_t st;
    pllc_pkg::pllc_state_t next_st;
    logic [7:0] stab_cnt;
    logic [7:0] next_stab_cnt;
    logic [3:0] win_cnt;
    logic [3:0] next_win_cnt;
    logic [7:0] fb_cnt;
    logic [7:0] next_fb_cnt;
    logic det_track;
    logic next_det_track;
    logic next_lock;
    logic next_pll_enable;
    logic next_filter_track;
    logic pon_drop;
    logic lock_chg;
    logic [7:0] diff;

    logic vco_s;
    logic vco_d;
    logic supply_ok;
    logic vco_edge;
    logic fb_tick;
    logic running;
    logic slow_hold;
    logic [7:0] slow_limit;

    // Both async pins pass two flops before any logic sees them
    pllc_sync u_vco_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .din(VCO_CLK),
        .dout(vco_s)
    );

    pllc_sync u_sup_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .din(PLL_SUPPLY_OK),
        .dout(supply_ok)
    );

    assign vco_edge = vco_s & ~vco_d;
    assign running = (st == pllc_pkg::ST_RUN);

    pllc_div #(
        .W(3)
    ) u_ref_div (
        .clk(MCLK),
        .rst(SYS_RST),
        .en(1'b1),
        .hold(1'b0),
        .limit(refdiv),
        .tick(REF_TICK)
    );

    // Feedback only counts while running, so a stale count never leaks in
    pllc_div #(
        .W(6)
    ) u_fb_div (
        .clk(MCLK),
        .rst(SYS_RST),
        .en(vco_edge),
        .hold(~running),
        .limit(mult),
        .tick(fb_tick)
    );

    // Zero in the slow field stops the slow tick
    assign slow_hold = (slow == 6'h00);
    assign slow_limit = {slow, 2'b00} - 8'h01;

    pllc_div #(
        .W(8)
    ) u_slow_div (
        .clk(MCLK),
        .rst(SYS_RST),
        .en(1'b1),
        .hold(slow_hold),
        .limit(slow_limit),
        .tick(SLOW_TICK)
    );

    // Sequencer and lock detector
    always_comb
    begin
        next_st = st;
        next_stab_cnt = stab_cnt;
        next_win_cnt = win_cnt;
        next_fb_cnt = fb_cnt;
        next_det_track = det_track;
        next_lock = PLL_LOCKED;
        pon_drop = 1'b0;
        diff = (fb_cnt > pllc_pkg::FB_EXPECT) ? fb_cnt - pllc_pkg::FB_EXPECT
            : pllc_pkg::FB_EXPECT - fb_cnt;
        case (st)
            pllc_pkg::ST_OFF:
            begin
                if (ctrl.pll_power_on && supply_ok)
                    next_st = pllc_pkg::ST_STAB;
            end
            pllc_pkg::ST_STAB:
            begin
                next_stab_cnt = stab_cnt + 8'h01;
                if (!ctrl.pll_power_on || !supply_ok)
                    next_st = pllc_pkg::ST_OFF;
                else if (STOP_MODE)
                    next_st = pllc_pkg::ST_HALT;
                else if (stab_cnt == 8'(pllc_pkg::STAB_CYC - 1))
                    next_st = pllc_pkg::ST_RUN;
            end
            pllc_pkg::ST_RUN:
            begin
                // WAIT is not a stop condition: the loop keeps running
                if (!ctrl.pll_power_on || !supply_ok)
                    next_st = pllc_pkg::ST_OFF;
                else if (STOP_MODE)
                    next_st = pllc_pkg::ST_HALT;
            end
            pllc_pkg::ST_HALT:
            begin
                if (!ctrl.pll_power_on || !supply_ok)
                    next_st = pllc_pkg::ST_OFF;
                else if (!STOP_MODE)
                begin
                    // Manual mode does not resume on its own after STOP
                    if (ctrl.auto_bw)
                        next_st = pllc_pkg::ST_STAB;
                    else
                    begin
                        next_st = pllc_pkg::ST_OFF;
                        pon_drop = 1'b1;
                    end
                end
            end
            default:
                next_st = pllc_pkg::ST_OFF;
        endcase
        if (next_st != pllc_pkg::ST_STAB)
            next_stab_cnt = 8'h00;

        // Lock drops with loop power, so it is never seen with the loop off
        if (!running || (next_st != pllc_pkg::ST_RUN))
        begin
            next_win_cnt = 4'h0;
            next_fb_cnt = 8'h00;
            next_det_track = 1'b0;
            next_lock = 1'b0;
        end
        else
        begin
            // Saturate so a runaway VCO cannot wrap back into tolerance
            if (fb_tick && fb_cnt != 8'hFF)
                next_fb_cnt = fb_cnt + 8'h01;
            if (REF_TICK)
            begin
                next_win_cnt = win_cnt + 4'h1;
                if (win_cnt == pllc_pkg::WIN_LAST)
                begin
                    next_fb_cnt = {7'h00, fb_tick};
                    if (diff <= pllc_pkg::LOCK_TOL)
                        next_lock = 1'b1;
                    else if (diff > pllc_pkg::UNL_TOL)
                        next_lock = 1'b0;
                    if (diff <= pllc_pkg::TRK_TOL)
                        next_det_track = 1'b1;
                    else if (diff > pllc_pkg::UNT_TOL)
                        next_det_track = 1'b0;
                end
            end
        end
        lock_chg = (next_lock != PLL_LOCKED);
        next_pll_enable = (next_st == pllc_pkg::ST_STAB) || (next_st == pllc_pkg::ST_RUN);
        // Auto follows the detector; manual follows the control bit
        if (ctrl.auto_bw)
            next_filter_track = next_det_track;
        else
            next_filter_track = ctrl.filter_track_select;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            st <= pllc_pkg::ST_OFF;
            stab_cnt <= 8'h00;
            win_cnt <= 4'h0;
            fb_cnt <= 8'h00;
            det_track <= 1'b0;
            PLL_LOCKED <= 1'b0;
            PLL_ENABLE <= 1'b0;
            FILTER_TRACK <= 1'b0;
            vco_d <= 1'b0;
        end
        else
        begin
            st <= next_st;
            stab_cnt <= next_stab_cnt;
            win_cnt <= next_win_cnt;
            fb_cnt <= next_fb_cnt;
            det_track <= next_det_track;
            PLL_LOCKED <= next_lock;
            PLL_ENABLE <= next_pll_enable;
            FILTER_TRACK <= next_filter_track;
            vco_d <= vco_s;
        end
    end

    // Register file and interrupt
    always_comb
    begin
        next_ctrl = ctrl;
        next_clksel = clksel;
        next_refdiv = refdiv;
        next_mult = mult;
        next_slow = slow;
        next_lock_change_irq_enable = lock_change_irq_enable;
        next_irq_stat = irq_stat;
        next_rd_data = 8'h00;
        if (WR_EN)
        begin
            if (ADDR == pllc_pkg::OFF_CTRL)
            begin
                next_ctrl = pllc_pkg::pllc_ctrl_t'(WR_DATA[4:0]);
                // Track bit is an indicator only under auto control
                if (ctrl.auto_bw)
                    next_ctrl.filter_track_select = ctrl.filter_track_select;
            end
            else if (ADDR == pllc_pkg::OFF_REFDIV)
                next_refdiv = WR_DATA[2:0];
            else if (ADDR == pllc_pkg::OFF_MULT)
                next_mult = WR_DATA[5:0];
            else if (ADDR == pllc_pkg::OFF_SLOW)
                next_slow = WR_DATA[5:0];
            else if (ADDR == pllc_pkg::OFF_IRQ_MASK)
                next_lock_change_irq_enable = WR_DATA[0];
            else if (ADDR == pllc_pkg::OFF_CLK_SEL)
                next_clksel = pllc_pkg::pllc_clksel_t'(WR_DATA[2:0]);
        end
        if (pon_drop)
            next_ctrl.pll_power_on = 1'b0;
        if (RD_EN)
        begin
            if (ADDR == pllc_pkg::OFF_CTRL)
            begin
                next_rd_data[4:0] = ctrl;
                next_rd_data[1] = FILTER_TRACK;
            end
            else if (ADDR == pllc_pkg::OFF_REFDIV)
                next_rd_data[2:0] = refdiv;
            else if (ADDR == pllc_pkg::OFF_MULT)
                next_rd_data[5:0] = mult;
            else if (ADDR == pllc_pkg::OFF_SLOW)
                next_rd_data[5:0] = slow;
            else if (ADDR == pllc_pkg::OFF_STAT)
            begin
                next_rd_data[pllc_pkg::BIT_LOCK] = PLL_LOCKED;
                next_rd_data[pllc_pkg::BIT_TRACK] = FILTER_TRACK;
            end
            else if (ADDR == pllc_pkg::OFF_IRQ_STAT)
            begin
                next_rd_data[0] = irq_stat;
                next_irq_stat = 1'b0;
            end
            else if (ADDR == pllc_pkg::OFF_IRQ_MASK)
                next_rd_data[0] = lock_change_irq_enable;
            else if (ADDR == pllc_pkg::OFF_CLK_SEL)
                next_rd_data[2:0] = clksel;
        end
        // A lock change in the clearing cycle still lands
        if (lock_chg)
            next_irq_stat = 1'b1;
        next_irq = next_irq_stat & next_lock_change_irq_enable;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl <= pllc_pkg::CTRL_RST;
            clksel <= pllc_pkg::CLKSEL_RST;
            refdiv <= pllc_pkg::REFDIV_RST;
            mult <= pllc_pkg::MULT_RST;
            slow <= pllc_pkg::SLOW_RST;
            lock_change_irq_enable <= 1'b0;
            irq_stat <= 1'b0;
            IRQ <= 1'b0;
            RD_DATA <= 8'h00;
            CLK_MON_EN <= 1'b1;
            LIMP_HOME_DIS <= 1'b0;
            CLK_SEL <= pllc_pkg::CLKSEL_RST;
        end
        else
        begin
            ctrl <= next_ctrl;
            clksel <= next_clksel;
            refdiv <= next_refdiv;
            mult <= next_mult;
            slow <= next_slow;
            lock_change_irq_enable <= next_lock_change_irq_enable;
            irq_stat <= next_irq_stat;
            IRQ <= next_irq;
            RD_DATA <= next_rd_data;
            CLK_MON_EN <= next_ctrl.clock_monitor_enable;
            LIMP_HOME_DIS <= next_ctrl.limp_home_disable;
            CLK_SEL <= next_clksel;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    lock_event_a: assert property ($changed(PLL_LOCKED) |-> irq_stat)
        else $error("Lock change did not set interrupt status");
    irq_level_a: assert property (IRQ == (irq_stat && lock_change_irq_enable))
        else $error("Interrupt output disagrees with status and enable");
    irq_hold_a: assert property (irq_stat && !RD_EN |=> irq_stat)
        else $error("Interrupt status dropped without a read");
    stop_off_a: assert property (STOP_MODE && running |=> !PLL_ENABLE ##1 !PLL_LOCKED)
        else $error("PLL kept running in STOP");
    stab_nolock_a: assert property (st == pllc_pkg::ST_STAB |-> !PLL_LOCKED)
        else $error("Lock reported during stabilisation");
    manual_track_a: assert property (!ctrl.auto_bw |=> FILTER_TRACK == $past(ctrl.filter_track_select))
        else $error("Manual filter mode not applied");
    auto_ro_a: assert property (WR_EN && ADDR == pllc_pkg::OFF_CTRL && ctrl.auto_bw |=>
        $stable(ctrl.filter_track_select))
        else $error("Track bit written in auto mode");
    stat_read_a: assert property (RD_EN && ADDR == pllc_pkg::OFF_STAT |=>
        RD_DATA == {6'h00, $past(FILTER_TRACK), $past(PLL_LOCKED)})
        else $error("Status read does not show lock and mode");
    lock_run_a: assert property (PLL_LOCKED |-> PLL_ENABLE)
        else $error("Lock reported with PLL off");

    lock_rise_c: cover property ($rose(PLL_LOCKED));
    stop_resume_c: cover property (st == pllc_pkg::ST_HALT ##[1:300] st == pllc_pkg::ST_RUN);
    irq_c: cover property ($rose(IRQ));
    track_c: cover property (ctrl.auto_bw && $rose(FILTER_TRACK));
endmodule
`default_nettype wire

// >>> logic/pllc_pkg.sv
// Package for the PLL lock and bandwidth control block.
// Assumes one crystal clock MCLK at 100 MHz and an 8-bit register port.
package pllc_pkg;

    // Register offsets on the 3-bit register port
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_REFDIV = 3'h1;
    localparam logic [2:0] OFF_MULT = 3'h2;
    localparam logic [2:0] OFF_SLOW = 3'h3;
    localparam logic [2:0] OFF_STAT = 3'h4;
    localparam logic [2:0] OFF_IRQ_STAT = 3'h5;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h6;
    localparam logic [2:0] OFF_CLK_SEL = 3'h7;

    // Status register bit positions
    localparam int BIT_LOCK = 0;
    localparam int BIT_TRACK = 1;

    // Control register, bit 0 upward: auto, track, power, monitor, limp
    typedef struct packed {
        logic limp_home_disable;
        logic clock_monitor_enable;
        logic pll_power_on;
        logic filter_track_select;
        logic auto_bw;
    } pllc_ctrl_t;

    // Clock mux selects: bit 0 module, bit 1 CAN, bit 2 debug
    typedef struct packed {
        logic debug_sel;
        logic can_sel;
        logic module_sel;
    } pllc_clksel_t;

    localparam logic [4:0] CTRL_RST = 5'h0D;
    localparam logic [2:0] REFDIV_RST = 3'h0;
    localparam logic [5:0] MULT_RST = 6'h00;
    localparam logic [5:0] SLOW_RST = 6'h00;
    localparam logic [2:0] CLKSEL_RST = 3'h0;

    // Stabilisation time after power-up or STOP exit
    localparam int CLK_MHZ = 100;
    localparam int STAB_NS = 1000;
    localparam int STAB_CYC = (STAB_NS * CLK_MHZ + 999) / 1000;

    // Lock detector: feedback ticks counted over a window of reference ticks
    localparam logic [3:0] WIN_LAST = 4'hF;
    localparam logic [7:0] FB_EXPECT = 8'h10;
    localparam logic [7:0] LOCK_TOL = 8'h01;
    localparam logic [7:0] UNL_TOL = 8'h02;
    localparam logic [7:0] TRK_TOL = 8'h02;
    localparam logic [7:0] UNT_TOL = 8'h04;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_STAB = 4'h2,
        ST_RUN = 4'h4,
        ST_HALT = 4'h8
    } pllc_state_t;

endpackage

// >>> logic/pllc_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is quasi-static relative to MCLK.
`timescale 1ns/1ps
`default_nettype none
module pllc_sync (
    input wire logic clk, // Destination clock
    input wire logic rst, // Async reset, high
    input wire logic din, // Asynchronous level
    output logic dout // Synchronised level
);
    logic meta;
    logic next_meta;
    logic next_dout;

    always_comb
    begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule
`default_nettype wire

// >>> logic/pllc_div.sv
// Programmable divider: one tick per (limit + 1) enabled cycles.
// Assumes en and hold come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pllc_div #(
    parameter int W = 8 // Counter width
) (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic en, // Count enable
    input wire logic hold, // Clear and hold counter
    input wire logic [W-1:0] limit, // Terminal count
    output logic tick // One-cycle pulse
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;

    always_comb
    begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (hold)
            next_cnt = '0;
        else if (en)
        begin
            if (cnt >= limit)
            begin
                next_cnt = '0;
                next_tick = 1'b1;
            end
            else
                next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// >>> tb/pllc_vco_model.sv
// Behavioural VCO, charge pump and loop filter seen through the sense line.
// Assumes the bench sets the half period; the line rests low while unpowered.
`timescale 1ns/1ps
`default_nettype none
module pllc_vco_model (
    input wire logic en, // Loop power from the block
    input wire logic [7:0] half_ns, // Half period of the VCO in ns
    output logic vco // VCO sense line
);
    // Unpowered oscillator stands still low, no stale toggling
    initial
    begin
        vco = 1'b0;
        forever
        begin
            if (en === 1'b1)
            begin
                #(half_ns) vco = ~vco;
            end
            else
            begin
                vco = 1'b0;
                @(posedge en);
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/pllc_tb_top.sv
// Self-checking bench for the PLL lock and bandwidth control block.
// Assumes pllc_top and pllc_vco_model; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pllc_tb_top;
    logic MCLK, SYS_RST, WR_EN, RD_EN, PLL_SUPPLY_OK, STOP_MODE, vco;
    logic [2:0] ADDR;
    logic [7:0] WR_DATA, RD_DATA, half_ns;
    logic IRQ, PLL_ENABLE, FILTER_TRACK, PLL_LOCKED, CLK_MON_EN, LIMP_HOME_DIS;
    logic [2:0] CLK_SEL;
    logic REF_TICK, SLOW_TICK;
    int n_errors, compares, cycles, gap;

    pllc_top dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .VCO_CLK(vco), .PLL_SUPPLY_OK(PLL_SUPPLY_OK),
        .STOP_MODE(STOP_MODE), .RD_DATA(RD_DATA), .IRQ(IRQ), .PLL_ENABLE(PLL_ENABLE),
        .FILTER_TRACK(FILTER_TRACK), .PLL_LOCKED(PLL_LOCKED), .CLK_MON_EN(CLK_MON_EN),
        .LIMP_HOME_DIS(LIMP_HOME_DIS), .CLK_SEL(CLK_SEL), .REF_TICK(REF_TICK),
        .SLOW_TICK(SLOW_TICK));
    pllc_vco_model vco_far (.en(PLL_ENABLE), .half_ns(half_ns), .vco(vco));

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under 10000 cycles
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge MCLK);
        WR_EN <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge MCLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1;
        chk(RD_DATA, exp, what);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return PLL_LOCKED;
            1: return PLL_ENABLE;
            default: return IRQ;
        endcase
    endfunction

    task automatic wait_sig(input int s, input logic want, input int lim, input string what);
        int n;
        n = 0;
        while (pick(s) !== want && n < lim)
        begin
            @(posedge MCLK);
            #1;
            n++;
        end
        chk({7'h00, pick(s)}, {7'h00, want}, what);
    endtask

    task automatic tick_gap(input logic slow, output int g);
        int n;
        n = 0;
        while ((slow ? SLOW_TICK : REF_TICK) !== 1'b1 && n < 600)
        begin
            @(posedge MCLK);
            #1;
            n++;
        end
        @(posedge MCLK);
        #1;
        g = 1;
        while ((slow ? SLOW_TICK : REF_TICK) !== 1'b1 && g < 600)
        begin
            @(posedge MCLK);
            #1;
            g++;
        end
    endtask

    initial
    begin
        n_errors = 0;
        compares = 0;
        cycles = 0;
        {WR_EN, RD_EN, STOP_MODE} = 3'h0;
        ADDR = 3'h0;
        WR_DATA = 8'h00;
        PLL_SUPPLY_OK = 1'b1;
        // 40 ns half period: 16 VCO edges per window at divide 8
        half_ns = 8'h28;
        SYS_RST = 1'b1;
        repeat (2) @(posedge MCLK);
        #1;
        chk({7'h00, CLK_MON_EN}, 8'h01, "monitor in reset");
        chk({7'h00, PLL_ENABLE}, 8'h00, "loop off in reset");
        @(posedge MCLK);
        SYS_RST <= 1'b0;
        rchk(pllc_pkg::OFF_CTRL, 8'h0D, "ctrl reset");
        rchk(pllc_pkg::OFF_IRQ_MASK, 8'h00, "mask reset");
        chk({7'h00, LIMP_HOME_DIS}, 8'h00, "limp pin");
        $display("test reset done");

        wr(pllc_pkg::OFF_REFDIV, 8'hFF);
        rchk(pllc_pkg::OFF_REFDIV, 8'h07, "refdiv");
        wr(pllc_pkg::OFF_REFDIV, 8'h07);
        wr(pllc_pkg::OFF_CLK_SEL, 8'h05);
        rchk(pllc_pkg::OFF_CLK_SEL, 8'h05, "clksel");
        chk({5'h00, CLK_SEL}, 8'h05, "clksel pins");
        tick_gap(1'b0, gap);
        chk(gap[7:0], 8'h08, "ref period");
        wr(pllc_pkg::OFF_SLOW, 8'h01);
        tick_gap(1'b1, gap);
        chk(gap[7:0], 8'h04, "slow min");
        wr(pllc_pkg::OFF_SLOW, 8'h3F);
        tick_gap(1'b1, gap);
        chk(gap[7:0], 8'hFC, "slow max");
        $display("test dividers done");

        wr(pllc_pkg::OFF_IRQ_MASK, 8'h01);
        wait_sig(0, 1'b1, 1500, "lock");
        chk({7'h00, IRQ}, 8'h01, "irq on lock");
        rchk(pllc_pkg::OFF_STAT, 8'h03, "auto track");
        wr(pllc_pkg::OFF_CTRL, 8'h0F);
        chk({7'h00, FILTER_TRACK}, 8'h01, "track read only");
        repeat (20) @(posedge MCLK);
        #1;
        chk({7'h00, IRQ}, 8'h01, "irq held");
        rchk(pllc_pkg::OFF_IRQ_STAT, 8'h01, "irq status");
        chk({7'h00, IRQ}, 8'h00, "irq cleared");
        $display("test lock done");

        wr(pllc_pkg::OFF_MULT, 8'h01);
        wait_sig(0, 1'b0, 1000, "unlock by mult");
        chk({7'h00, IRQ}, 8'h01, "irq on unlock");
        // A cut first window may drop lock before track; let a full one pass
        repeat (130) @(posedge MCLK);
        #1;
        rchk(pllc_pkg::OFF_STAT, 8'h00, "untrack");
        rchk(pllc_pkg::OFF_IRQ_STAT, 8'h01, "irq status 2");
        wr(pllc_pkg::OFF_MULT, 8'h00);
        wait_sig(0, 1'b1, 1500, "relock");
        rchk(pllc_pkg::OFF_IRQ_STAT, 8'h01, "irq status 3");
        $display("test unlock done");

        @(posedge MCLK);
        STOP_MODE <= 1'b1;
        wait_sig(1, 1'b0, 5, "stop halts");
        repeat (20) @(posedge MCLK);
        STOP_MODE <= 1'b0;
        wait_sig(1, 1'b1, 10, "stop exit");
        wait_sig(0, 1'b1, 1500, "resume lock");
        rchk(pllc_pkg::OFF_CTRL, 8'h0F, "ctrl after stop");
        $display("test stop done");

        wr(pllc_pkg::OFF_IRQ_MASK, 8'h00);
        rchk(pllc_pkg::OFF_IRQ_STAT, 8'h01, "irq status 4");
        // Manual start: track cleared before power returns
        wr(pllc_pkg::OFF_CTRL, 8'h08);
        wait_sig(1, 1'b0, 5, "manual off");
        wr(pllc_pkg::OFF_CTRL, 8'h0C);
        chk({7'h00, FILTER_TRACK}, 8'h00, "manual acq");
        wait_sig(0, 1'b1, 1500, "manual lock");
        chk({7'h00, IRQ}, 8'h00, "masked irq");
        rchk(pllc_pkg::OFF_IRQ_STAT, 8'h01, "masked status");
        // Lock proves the acquisition wait has passed
        wr(pllc_pkg::OFF_CTRL, 8'h0E);
        @(posedge MCLK);
        #1;
        chk({7'h00, FILTER_TRACK}, 8'h01, "manual track");
        rchk(pllc_pkg::OFF_CTRL, 8'h0E, "ctrl manual");
        wr(pllc_pkg::OFF_CTRL, 8'h0C);
        rchk(pllc_pkg::OFF_STAT, 8'h01, "acq bit zero");
        // Manual mode must not resume after STOP: power bit is cleared
        @(posedge MCLK);
        STOP_MODE <= 1'b1;
        wait_sig(1, 1'b0, 5, "manual stop");
        @(posedge MCLK);
        STOP_MODE <= 1'b0;
        repeat (2) @(posedge MCLK);
        #1;
        chk({7'h00, PLL_ENABLE}, 8'h00, "manual stays off");
        rchk(pllc_pkg::OFF_CTRL, 8'h08, "manual no resume");
        wr(pllc_pkg::OFF_CTRL, 8'h10);
        chk({6'h00, LIMP_HOME_DIS, CLK_MON_EN}, 8'h02, "limp and monitor pins");
        $display("test manual done");
        print_verdict();
    end
endmodule
`default_nettype wire
